// File: pkg/usbsp_pkg.sv
// Constants, types and helpers for the SPI port of the USB bridge.
// Assumes a 100 MHz core clock and pins that are synchronous to it.
package usbsp_pkg;

  localparam int CLK_KHZ        = 100000;
  localparam int SPI_MAX_KHZ    = 3000;
  localparam int SSEL_SETUP_NS  = 100;
  localparam int CLK_PERIOD_NS  = 1000000 / CLK_KHZ;

  // Least half period of the serial clock, rounded up
  localparam int SCLK_HALF_CYC  = (CLK_KHZ + 2 * SPI_MAX_KHZ - 1) / (2 * SPI_MAX_KHZ);
  // Least select-to-first-edge time, rounded up
  localparam int SSEL_SETUP_CYC = (SSEL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] HALF_LAST  = CNT_W'(SCLK_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SSEL_SETUP_CYC - 1);

  localparam int WORD_W = 16;
  localparam logic [4:0] WL_MIN   = 5'h04;
  localparam logic [4:0] WL_MAX   = 5'h10;
  localparam logic [4:0] WL_RESET = 5'h08;

  localparam logic MODE_MASTER = 1'b0;
  localparam logic MODE_SLAVE  = 1'b1;
  localparam logic WAKE_POL_RESET = 1'b1;
  localparam logic CPOL_RESET  = 1'b0;
  localparam logic CPHA_RESET  = 1'b0;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_SETUP = 4'h2,
    ST_SHIFT = 4'h4,
    ST_END   = 4'h8
  } usbsp_state_t;

  // Word length held inside 4..16
  function automatic logic [4:0] usbsp_clamp_wl(input logic [4:0] wl);
    if (wl < WL_MIN) return WL_MIN;
    if (wl > WL_MAX) return WL_MAX;
    return wl;
  endfunction

  // Keeps the low wl bits of a word
  function automatic logic [WORD_W-1:0] usbsp_mask(input logic [WORD_W-1:0] d,
                                                  input logic [4:0]        wl);
    logic [WORD_W-1:0] m;
    m = '0;
    for (int i = 0; i < WORD_W; i++) begin
      if (i < int'(wl)) begin
        m[i] = 1'b1;
      end
    end
    return d & m;
  endfunction

endpackage

// File: rtl/usbsp_port_top.sv
// SPI serial port of the USB bridge with its sideband pins.
// Assumes all pin inputs are synchronous to clk_in; pads resolve the enables.
// What this block does
// RULE_01 - Without stored configuration the port runs as SPI master, mode zero.
// RULE_02 - Select and clock are driven outputs as master, inputs as slave.
// RULE_03 - Master-out data line is driven as master, sampled as slave.
// RULE_04 - Master-in data line is sampled as master, driven as slave.
// RULE_05 - External master asserts select at least 100 ns before first clock edge.
// RULE_06 - Activity LED output shows SPI data being sent or received.
// RULE_07 - Suspend output is high while in low power, low after it ends.
// RULE_08 - Active wakeup input during suspend ends suspend.
// RULE_09 - Wakeup active level is chosen by stored configuration.
// RULE_10 - Power-control output tells whether the USB function is unconfigured or suspended.
// RULE_11 - Power-control low when configured and not suspended, high when unconfigured or suspended.
// RULE_12 - Chip reset is active low; a pulled-up input means no reset.
// RULE_13 - Every pin is released to high impedance while reset is asserted.
// RULE_14 - Serial clock at most 3 MHz; word length 4 to 16 bits.
`timescale 1ns/1ps
module usbsp_port_top (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        chip_reset_n_in,
  input  wire logic        cfg_valid_in,
  input  wire logic        cfg_slave_mode_in,
  input  wire logic        cfg_wake_high_in,
  input  wire logic        cfg_cpol_in,
  input  wire logic        cfg_cpha_in,
  input  wire logic [4:0]  cfg_word_len_in,
  input  wire logic        tx_valid_in,
  input  wire logic [15:0] tx_data_in,
  output logic             tx_ready_out,
  output logic             rx_valid_out,
  output logic [15:0]      rx_data_out,
  input  wire logic        spi_ssel_n_in,
  output logic             spi_ssel_n_out,
  output logic             spi_ssel_n_oe_out,
  input  wire logic        spi_sclk_in,
  output logic             spi_sclk_out,
  output logic             spi_sclk_oe_out,
  input  wire logic        spi_mosi_in,
  output logic             spi_mosi_out,
  output logic             spi_mosi_oe_out,
  input  wire logic        spi_miso_in,
  output logic             spi_miso_out,
  output logic             spi_miso_oe_out,
  input  wire logic        usb_configured_in,
  input  wire logic        usb_suspend_in,
  input  wire logic        wakeup_in,
  output logic             wake_event_out,
  output logic             transfer_activity_led_out,
  output logic             suspend_out,
  output logic             power_gate_out,
  output logic             side_pins_oe_out
);

  // Core reset; an open chip reset pin is pulled up and so inactive
  logic rst_any;
  assign rst_any = rst_in || !chip_reset_n_in;  // [RULE_12]

  // Stored configuration
  logic        mode_reg;
  logic        wake_pol_reg;
  logic        cpol_reg;
  logic        cpha_reg;
  logic [4:0]  wl_reg;

  // Transfer state
  usbsp_pkg::usbsp_state_t state_reg;
  usbsp_pkg::usbsp_state_t state_next;
  logic [usbsp_pkg::CNT_W-1:0] setup_cnt_reg;
  logic [4:0]  k_reg;
  logic [15:0] tx_sh_reg;
  logic [15:0] rx_sh_reg;
  logic [15:0] tx_hold_reg;
  logic        tx_full_reg;
  logic        sclk_reg;
  logic        sclk_prev_reg;
  logic        ssel_prev_reg;
  logic [15:0] rx_data_reg;
  logic        rx_valid_reg;
  logic        led_reg;

  // Sideband state
  logic        suspend_reg;
  logic        usb_susp_prev_reg;
  logic        wake_ev_reg;

  // Decode
  logic        is_master;
  logic        is_slave;
  logic        slave_sel;
  logic        slave_start;
  logic        tick;
  logic        edge_ev;
  logic        cap_ev;
  logic        drv_ev;
  logic        last_ev;
  logic        din;
  logic        dout;
  logic        port_idle;
  logic        master_go;
  logic        load_ev;
  logic        wake_hit;
  logic        susp_enter;
  logic [4:0]  last_k;
  logic [15:0] rx_word;
  logic [15:0] load_word;

  assign is_master   = (mode_reg == usbsp_pkg::MODE_MASTER);
  assign is_slave    = (mode_reg == usbsp_pkg::MODE_SLAVE);
  assign slave_sel   = is_slave && !spi_ssel_n_in;
  // Slave relies on the far master's select-to-clock setup time
  assign slave_start = slave_sel && ssel_prev_reg;  // [RULE_05]
  assign port_idle   = (state_reg == usbsp_pkg::ST_IDLE) && !slave_sel;
  assign master_go   = is_master && tx_full_reg && !suspend_reg
                       && (state_reg == usbsp_pkg::ST_IDLE);

  usbsp_sclk_gen u_sclk_gen (
    .clk_in   (clk_in),
    .rst_in   (rst_any),
    .run_in   (state_reg == usbsp_pkg::ST_SHIFT),
    .tick_out (tick)
  );  // [RULE_14]

  // One edge per half period as master, per sampled clock change as slave
  assign edge_ev = is_master ? ((state_reg == usbsp_pkg::ST_SHIFT) && tick)
                             : (slave_sel && !slave_start && (spi_sclk_in != sclk_prev_reg));
  assign last_k  = 5'((wl_reg << 1) - 5'h01);
  assign cap_ev  = edge_ev && (k_reg[0] == cpha_reg);
  assign drv_ev  = edge_ev && (k_reg[0] != cpha_reg) && (k_reg != 5'h00);
  assign last_ev = edge_ev && (k_reg == last_k);

  assign din  = is_master ? spi_miso_in : spi_mosi_in;  // [RULE_03] [RULE_04]
  assign dout = tx_sh_reg[4'(wl_reg - 5'h01)];
  assign rx_word = usbsp_pkg::usbsp_mask(cap_ev ? {rx_sh_reg[14:0], din} : rx_sh_reg,
                                         wl_reg);
  // Slave underrun sends zeros rather than stale data
  assign load_word = tx_full_reg ? tx_hold_reg : 16'h0000;
  assign load_ev   = master_go || (is_slave && (slave_start || (slave_sel && last_ev)));

  assign tx_ready_out = !tx_full_reg && !rst_any;

  // Master sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      usbsp_pkg::ST_IDLE: begin
        if (master_go) begin
          state_next = usbsp_pkg::ST_SETUP;
        end
      end
      usbsp_pkg::ST_SETUP: begin
        // Select leads the first clock edge by the setup time we ask of others plus a half period
        if (setup_cnt_reg == usbsp_pkg::SETUP_LAST) begin
          state_next = usbsp_pkg::ST_SHIFT;
        end
      end
      usbsp_pkg::ST_SHIFT: begin
        if (last_ev) begin
          state_next = usbsp_pkg::ST_END;
        end
      end
      usbsp_pkg::ST_END: begin
        if (setup_cnt_reg == usbsp_pkg::SETUP_LAST) begin
          state_next = usbsp_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Configuration; mode only changes while the port is quiet
  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      mode_reg     <= usbsp_pkg::MODE_MASTER;  // [RULE_01]
      wake_pol_reg <= usbsp_pkg::WAKE_POL_RESET;
      cpol_reg     <= usbsp_pkg::CPOL_RESET;
      cpha_reg     <= usbsp_pkg::CPHA_RESET;
      wl_reg       <= usbsp_pkg::WL_RESET;
    end else if (cfg_valid_in && port_idle) begin
      mode_reg     <= cfg_slave_mode_in;
      wake_pol_reg <= cfg_wake_high_in;  // [RULE_09]
      cpol_reg     <= cfg_cpol_in;
      cpha_reg     <= cfg_cpha_in;
      wl_reg       <= usbsp_pkg::usbsp_clamp_wl(cfg_word_len_in);  // [RULE_14]
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      state_reg     <= usbsp_pkg::ST_IDLE;
      setup_cnt_reg <= '0;
    end else begin
      state_reg     <= state_next;
      setup_cnt_reg <= (state_next != state_reg) ? '0 : setup_cnt_reg + 1'b1;
    end
  end

  // Holding register for the next word
  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      tx_full_reg <= 1'b0;
      tx_hold_reg <= 16'h0000;
    end else if (tx_valid_in && tx_ready_out) begin
      tx_full_reg <= 1'b1;
      tx_hold_reg <= tx_data_in;
    end else if (load_ev) begin
      tx_full_reg <= 1'b0;
    end
  end

  // Shift engine shared by both modes, MSB first
  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      tx_sh_reg <= 16'h0000;
      rx_sh_reg <= 16'h0000;
      k_reg     <= 5'h00;
    end else if (load_ev) begin
      tx_sh_reg <= load_word;
      rx_sh_reg <= 16'h0000;
      k_reg     <= 5'h00;
    end else if (is_slave && !slave_sel) begin
      k_reg     <= 5'h00;
    end else if (edge_ev) begin
      k_reg     <= last_ev ? 5'h00 : k_reg + 5'h01;
      if (cap_ev) begin
        rx_sh_reg <= {rx_sh_reg[14:0], din};
      end
      if (drv_ev) begin
        tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      rx_valid_reg <= 1'b0;
      rx_data_reg  <= 16'h0000;
    end else begin
      rx_valid_reg <= last_ev;
      if (last_ev) begin
        rx_data_reg <= rx_word;
      end
    end
  end

  // Master clock idles at the chosen polarity
  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      sclk_reg <= usbsp_pkg::CPOL_RESET;
    end else if ((state_reg == usbsp_pkg::ST_SHIFT) && tick) begin
      sclk_reg <= !sclk_reg;
    end else if (state_reg != usbsp_pkg::ST_SHIFT) begin
      sclk_reg <= cpol_reg;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      sclk_prev_reg <= 1'b0;
      ssel_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= spi_sclk_in;
      ssel_prev_reg <= spi_ssel_n_in;
    end
  end

  // Lit while a word is in flight in either mode
  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      led_reg <= 1'b0;
    end else begin
      led_reg <= (state_reg != usbsp_pkg::ST_IDLE) || slave_sel;  // [RULE_06]
    end
  end

  // Suspend: entered on the USB engine's request, left by wakeup or resume
  assign wake_hit   = suspend_reg && (wakeup_in == wake_pol_reg);  // [RULE_08] [RULE_09]
  assign susp_enter = usb_suspend_in && !usb_susp_prev_reg;

  always_ff @(posedge clk_in) begin
    if (rst_any) begin
      suspend_reg       <= 1'b0;
      usb_susp_prev_reg <= 1'b0;
      wake_ev_reg       <= 1'b0;
    end else begin
      usb_susp_prev_reg <= usb_suspend_in;
      wake_ev_reg       <= wake_hit;
      // Wake beats a fresh entry so a held wakeup is never swallowed
      if (wake_hit || !usb_suspend_in) begin
        suspend_reg <= 1'b0;  // [RULE_07] [RULE_08]
      end else if (susp_enter) begin
        suspend_reg <= 1'b1;  // [RULE_07]
      end
    end
  end

  // Pin directions follow the mode; all released while in reset
  assign spi_ssel_n_oe_out = !rst_any && is_master;  // [RULE_02] [RULE_13]
  assign spi_sclk_oe_out   = !rst_any && is_master;  // [RULE_02] [RULE_13]
  assign spi_mosi_oe_out   = !rst_any && is_master;  // [RULE_03] [RULE_13]
  assign spi_miso_oe_out   = !rst_any && is_slave;   // [RULE_04] [RULE_13]
  assign side_pins_oe_out  = !rst_any;               // [RULE_13]

  assign spi_ssel_n_out = (state_reg == usbsp_pkg::ST_IDLE);  // [RULE_02]
  assign spi_sclk_out   = sclk_reg;                            // [RULE_02]
  assign spi_mosi_out   = dout;                                // [RULE_03]
  assign spi_miso_out   = dout;                                // [RULE_04]

  assign rx_valid_out   = rx_valid_reg;
  assign rx_data_out    = rx_data_reg;
  assign wake_event_out = wake_ev_reg;
  assign transfer_activity_led_out = led_reg;
  assign suspend_out    = suspend_reg;  // [RULE_07]
  // Gate power off unless configured and awake
  assign power_gate_out = !usb_configured_in || suspend_reg;  // [RULE_10] [RULE_11]

endmodule

// File: rtl/usbsp_sclk_gen.sv
// Half-period tick generator for the master serial clock.
// Assumes run_in stays high for the whole shifting phase.
`timescale 1ns/1ps
module usbsp_sclk_gen (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic run_in,
  output logic      tick_out
);

  logic [usbsp_pkg::CNT_W-1:0] cnt_reg;
  logic [usbsp_pkg::CNT_W-1:0] cnt_next;
  logic                        at_end;

  assign at_end   = (cnt_reg == usbsp_pkg::HALF_LAST);
  assign cnt_next = (!run_in || at_end) ? '0 : cnt_reg + 1'b1;
  // Never faster than the 3 MHz ceiling
  assign tick_out = run_in && at_end;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

// File: verif/usbsp_port_monitor.sv
// Port checker: pin directions, clock pacing, LED, suspend and power gate.
// Assumes binding to usbsp_port_top; sees its ports only.
`timescale 1ns/1ps
module usbsp_port_monitor (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic chip_reset_n_in,
  input wire logic usb_configured_in,
  input wire logic usb_suspend_in,
  input wire logic tx_ready_out,
  input wire logic rx_valid_out,
  input wire logic spi_ssel_n_out,
  input wire logic spi_ssel_n_oe_out,
  input wire logic spi_sclk_out,
  input wire logic spi_sclk_oe_out,
  input wire logic spi_mosi_oe_out,
  input wire logic spi_miso_oe_out,
  input wire logic wake_event_out,
  input wire logic transfer_activity_led_out,
  input wire logic suspend_out,
  input wire logic power_gate_out,
  input wire logic side_pins_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in || !chip_reset_n_in);
  logic       sclk_last_reg;
  logic [7:0] hold_reg;
  wire logic  sclk_moved = spi_sclk_out != sclk_last_reg;
  // Saturates at reset so the first edge after reset is not flagged
  always_ff @(posedge clk_in) begin
    sclk_last_reg <= spi_sclk_out;
    hold_reg      <= (rst_in || !chip_reset_n_in) ? 8'hFF : sclk_moved ? 8'h00 :
                     (hold_reg == 8'hFF) ? hold_reg : hold_reg + 8'h01;
  end
  pins_off_reset_a: assert property (disable iff (1'b0) rst_in |-> !(spi_ssel_n_oe_out ||
    spi_sclk_oe_out || spi_mosi_oe_out || spi_miso_oe_out || side_pins_oe_out || tx_ready_out))
    else $error("pin enabled during reset");
  chip_reset_off_a: assert property (disable iff (rst_in) !chip_reset_n_in |->
    !side_pins_oe_out && !spi_sclk_oe_out && !spi_miso_oe_out) else $error("chip reset ignored");
  master_default_a: assert property (($fell(rst_in) || $rose(chip_reset_n_in)) |->
    spi_sclk_oe_out && !spi_miso_oe_out && spi_ssel_n_out) else $error("not master after reset");
  pin_dirs_a: assert property (spi_ssel_n_oe_out == spi_sclk_oe_out &&
    spi_mosi_oe_out == spi_sclk_oe_out && spi_miso_oe_out != spi_mosi_oe_out)
    else $error("pin directions disagree");
  sclk_pace_a: assert property (spi_sclk_oe_out && sclk_moved |-> hold_reg >= 8'h10)
    else $error("serial clock too fast");
  sclk_in_frame_a: assert property (spi_sclk_oe_out && sclk_moved |-> !spi_ssel_n_out)
    else $error("clock outside select");
  led_on_a: assert property ($fell(spi_ssel_n_out) && spi_ssel_n_oe_out |-> ##[0:2]
    transfer_activity_led_out) else $error("activity led missing");
  suspend_exit_a: assert property (suspend_out && !usb_suspend_in |=> !suspend_out)
    else $error("suspend not left");
  suspend_cause_a: assert property ($rose(suspend_out) |-> $past(usb_suspend_in))
    else $error("suspend without request");
  wake_exit_a: assert property (wake_event_out |-> $fell(suspend_out))
    else $error("wake without leaving suspend");
  power_gate_a: assert property (power_gate_out == (!usb_configured_in || suspend_out))
    else $error("power gate level wrong");
  cover property (rx_valid_out && spi_sclk_oe_out);
  cover property (rx_valid_out && spi_miso_oe_out);
  cover property (wake_event_out);
endmodule
bind usbsp_port_top usbsp_port_monitor mon (.clk_in(clk_in), .rst_in(rst_in),
  .chip_reset_n_in(chip_reset_n_in), .usb_configured_in(usb_configured_in),
  .usb_suspend_in(usb_suspend_in), .tx_ready_out(tx_ready_out), .rx_valid_out(rx_valid_out),
  .spi_ssel_n_out(spi_ssel_n_out), .spi_ssel_n_oe_out(spi_ssel_n_oe_out),
  .spi_sclk_out(spi_sclk_out), .spi_sclk_oe_out(spi_sclk_oe_out),
  .spi_mosi_oe_out(spi_mosi_oe_out), .spi_miso_oe_out(spi_miso_oe_out),
  .wake_event_out(wake_event_out), .transfer_activity_led_out(transfer_activity_led_out),
  .suspend_out(suspend_out), .power_gate_out(power_gate_out),
  .side_pins_oe_out(side_pins_oe_out));

// File: verif/usbsp_port_top_tb.sv
// Self-checking bench for the SPI port: master, slave, reset, suspend.
// Assumes the slave model on the far side and the bound port checker.
`timescale 1ns/1ps
module usbsp_port_top_tb;
  logic        clk_in = 1'b0, rst_in = 1'b1, chip_reset_n_in = 1'b1;
  logic        cfg_valid_in = 1'b0, cfg_slave_mode_in = 1'b0, cfg_wake_high_in = 1'b1;
  logic        cfg_cpol_in = 1'b0, cfg_cpha_in = 1'b0, tx_valid_in = 1'b0;
  logic [4:0]  cfg_word_len_in = 5'h08, mwl = 5'h08;
  logic [15:0] tx_data_in = 16'h0000, reply = 16'h0000, rx_data_out, got;
  logic        ext_ssel = 1'b1, ext_sclk = 1'b0, ext_mosi = 1'b0;
  logic        usb_configured_in = 1'b0, usb_suspend_in = 1'b0, wakeup_in = 1'b0;
  logic        tx_ready_out, rx_valid_out, ss_o, ss_oe, sk_o, sk_oe, mo_o, mo_oe, mi_o, mi_oe;
  logic        wake_ev, led, susp, pg, side_oe, mdl_miso;
  int          n_mismatch = 0, n_compared = 0;
  wire logic   ssel_w = ss_oe ? ss_o : ext_ssel;
  wire logic   sclk_w = sk_oe ? sk_o : ext_sclk;
  wire logic   mosi_w = mo_oe ? mo_o : ext_mosi;
  wire logic   miso_w = mi_oe ? mi_o : mdl_miso;
  wire logic [5:0] pins_w = {ss_oe, sk_oe, mo_oe, mi_oe, side_oe, tx_ready_out};
  always #5 clk_in = ~clk_in;
  usbsp_port_top dut (.clk_in(clk_in), .rst_in(rst_in), .chip_reset_n_in(chip_reset_n_in),
    .cfg_valid_in(cfg_valid_in), .cfg_slave_mode_in(cfg_slave_mode_in),
    .cfg_wake_high_in(cfg_wake_high_in), .cfg_cpol_in(cfg_cpol_in), .cfg_cpha_in(cfg_cpha_in),
    .cfg_word_len_in(cfg_word_len_in), .tx_valid_in(tx_valid_in), .tx_data_in(tx_data_in),
    .tx_ready_out(tx_ready_out), .rx_valid_out(rx_valid_out), .rx_data_out(rx_data_out),
    .spi_ssel_n_in(ssel_w), .spi_ssel_n_out(ss_o), .spi_ssel_n_oe_out(ss_oe),
    .spi_sclk_in(sclk_w), .spi_sclk_out(sk_o), .spi_sclk_oe_out(sk_oe),
    .spi_mosi_in(mosi_w), .spi_mosi_out(mo_o), .spi_mosi_oe_out(mo_oe),
    .spi_miso_in(miso_w), .spi_miso_out(mi_o), .spi_miso_oe_out(mi_oe),
    .usb_configured_in(usb_configured_in), .usb_suspend_in(usb_suspend_in),
    .wakeup_in(wakeup_in), .wake_event_out(wake_ev), .transfer_activity_led_out(led),
    .suspend_out(susp), .power_gate_out(pg), .side_pins_oe_out(side_oe));
  usbsp_spi_slave_model mdl (.ssel_n_in(ssel_w), .sclk_in(sclk_w), .mosi_in(mosi_w),
    .wl_in(mwl), .reply_in(reply), .miso_out(mdl_miso), .got_out(got));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [4:0] wlen(input logic [4:0] w);
    return (w < 5'h04) ? 5'h04 : (w > 5'h10) ? 5'h10 : w;
  endfunction
  function automatic logic [15:0] msk(input logic [15:0] d, input logic [4:0] w);
    return d & 16'((17'h00001 << w) - 17'h00001);
  endfunction
  task automatic setcfg(input logic [4:0] w, input logic slv);
    cfg_word_len_in = w;
    cfg_slave_mode_in = slv;
    cfg_valid_in = 1'b1;
    @(negedge clk_in) cfg_valid_in = 1'b0;
  endtask
  task automatic offer(input logic [15:0] d);
    tx_data_in = d;
    tx_valid_in = 1'b1;
    for (int t = 0; t < 2000 && tx_ready_out !== 1'b1; t++) @(negedge clk_in);
    chk("tx_ready", {15'h0000, tx_ready_out}, 16'h0001);
    @(negedge clk_in) tx_valid_in = 1'b0;
  endtask
  task automatic wait_rx();
    for (int t = 0; t < 3000 && rx_valid_out !== 1'b1; t++) @(negedge clk_in);
    chk("rx_valid", {15'h0000, rx_valid_out}, 16'h0001);
  endtask
  task automatic mxfer(input logic [4:0] w, input logic [15:0] tx, input logic [15:0] rp);
    mwl = wlen(w);
    reply = rp;
    setcfg(w, 1'b0);
    chk("master_pins", {10'h000, pins_w}, 16'h003B);
    offer(tx);
    repeat (3) @(negedge clk_in);
    chk("led_select", {14'h0000, led, ss_o}, 16'h0002);
    wait_rx();
    chk("rx_data", rx_data_out, msk(rp, mwl));
    chk("mosi_word", msk(got, mwl), msk(tx, mwl));
    repeat (12) @(negedge clk_in);
    chk("select_idle", {14'h0000, led, ss_o}, 16'h0001);
  endtask
  task automatic sxfer(input logic [15:0] tx, input logic [15:0] mo, input logic give,
                       input logic p, input logic h);
    logic [15:0] sg;
    sg = 16'h0000;
    cfg_cpol_in = p;
    cfg_cpha_in = h;
    setcfg(5'h08, 1'b1);
    chk("slave_pins", {10'h000, pins_w}, 16'h0007);
    ext_sclk = p;
    if (give) offer(tx);
    ext_ssel = 1'b0;
    repeat (12) @(negedge clk_in); // Select setup above 100 ns
    chk("led_slave", {15'h0000, led}, 16'h0001);
    for (int i = 7; i >= 0; i--) begin
      ext_mosi = mo[i];
      repeat (20) @(negedge clk_in);
      if (!h) sg = {sg[14:0], miso_w};
      ext_sclk = ~p;
      repeat (20) @(negedge clk_in);
      if (h) sg = {sg[14:0], miso_w};
      ext_sclk = p;
      // Trailing edge is taken before the next bit moves
      @(negedge clk_in);
    end
    wait_rx();
    chk("slave_rx", rx_data_out, msk(mo, 5'h08));
    chk("slave_tx", sg, give ? msk(tx, 5'h08) : 16'h0000);
    ext_ssel = 1'b1;
    ext_mosi = ~ext_mosi;
    ext_sclk = 1'b0;
    cfg_cpol_in = 1'b0;
    cfg_cpha_in = 1'b0;
  endtask
  task automatic susp_run(input logic wh);
    cfg_wake_high_in = wh;
    wakeup_in = ~wh;
    setcfg(5'h08, 1'b0);
    usb_suspend_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk("suspend_pg", {14'h0000, susp, pg}, 16'h0003);
    wakeup_in = wh;
    for (int t = 0; t < 5 && wake_ev !== 1'b1; t++) @(negedge clk_in);
    chk("wake", {14'h0000, wake_ev, susp}, 16'h0002);
    wakeup_in = ~wh;
    usb_suspend_in = 1'b0;
    repeat (2) @(negedge clk_in) usb_suspend_in = ~usb_suspend_in;
    repeat (2) @(negedge clk_in);
    chk("suspend_left", {14'h0000, susp, pg}, {15'h0000, ~usb_configured_in});
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
  initial begin
    logic [4:0] tab [4];
    tab = '{5'h04, 5'h10, 5'h02, 5'h1F};
    void'($urandom(32'h0AED824E));
    repeat (12) @(negedge clk_in);
    chk("reset_pins", {10'h000, pins_w}, 16'h0000);
    rst_in = 1'b0;
    @(negedge clk_in);
    chk("default_pins", {10'h000, pins_w}, 16'h003B);
    foreach (tab[i]) mxfer(tab[i], 16'($urandom), 16'($urandom));
    for (int i = 0; i < 4; i++) mxfer(5'($urandom_range(16, 4)), 16'($urandom), 16'($urandom));
    for (int i = 0; i < 4; i++) sxfer(16'($urandom), 16'($urandom), i < 3, i[1], i[0]);
    chip_reset_n_in = 1'b0;
    repeat (3) @(negedge clk_in);
    chk("chip_reset_pins", {10'h000, pins_w}, 16'h0000);
    chip_reset_n_in = 1'b1;
    @(negedge clk_in);
    chk("after_chip_reset", {10'h000, pins_w}, 16'h003B);
    susp_run(1'b1);
    usb_configured_in = 1'b1;
    susp_run(1'b0);
    summarize();
  end
endmodule

// File: verif/usbsp_spi_slave_model.sv
// Behavioural SPI slave peripheral, clock mode zero, MSB first.
// Assumes pins already resolved from the port's output enables.
`timescale 1ns/1ps
module usbsp_spi_slave_model (
  input  wire logic        ssel_n_in,
  input  wire logic        sclk_in,
  input  wire logic        mosi_in,
  input  wire logic [4:0]  wl_in,
  input  wire logic [15:0] reply_in,
  output logic             miso_out,
  output logic [15:0]      got_out
);
  logic [15:0] sh;
  initial begin
    miso_out = 1'b0;
    got_out  = 16'h0000;
  end
  always @(negedge ssel_n_in) begin
    sh       = reply_in;
    miso_out = reply_in[wl_in-1];
  end
  // Rising edge captures, falling edge shifts
  always @(posedge sclk_in) if (!ssel_n_in) got_out = {got_out[14:0], mosi_in};
  always @(negedge sclk_in) begin
    if (!ssel_n_in) begin
      sh       = sh << 1;
      miso_out = sh[wl_in-1];
    end
  end
  // Released line shows no stale bit
  always @(posedge ssel_n_in) miso_out = ~miso_out;
endmodule
